// *** core/irq_map_pkg.sv ***
// Interrupt input numbering shared by the expansion interrupt map and its helpers.
package irq_map_pkg;
	localparam int IRQ_COUNT = 131;
	localparam int SERIAL_PORTS = 6;
	localparam int SERIAL_LOW_PORTS = 5;
	localparam int DMA_CHANNELS = 3;
	localparam int GPIO3_COMB_WIDTH = 16;
	localparam int GPIO0_PIN_WIDTH = 16;
	localparam int GPIO1_PIN_WIDTH = 16;
	localparam int GPIO2_PIN_WIDTH = 4;
	localparam int GPIO3_PIN_WIDTH = 1;

	localparam int WDOG_RESET_IDX = 0;
	localparam int WDOG_IRQ_IDX = 1;
	localparam int SEC_MEM_IDX = 9;
	localparam int SEC_PERIPH_IDX = 10;
	localparam int SEC_MASTER_IDX = 11;
	localparam int SEC_BRIDGE_IDX = 12;
	localparam int TIMESTAMP_IDX = 32;
	localparam int SERIAL_RX_BASE = 33;
	localparam int SERIAL_TX_BASE = 34;
	localparam int SERIAL_PAIR_STEP = 2;
	localparam int SERIAL_COMB_BASE = 43;
	localparam int OVERFLOW_IDX = 48;
	localparam int ETH_IDX = 49;
	localparam int AUDIO_IDX = 50;
	localparam int TOUCH_IDX = 51;
	localparam int USB_IDX = 52;
	localparam int ADC_SPI_IDX = 53;
	localparam int SHIELD0_SPI_IDX = 54;
	localparam int SHIELD1_SPI_IDX = 55;
	localparam int NPU_IDX = 56;
	localparam int DMA_BASE = 60;
	localparam int DMA_STEP = 3;
	localparam int DMA_ERR_OFS = 0;
	localparam int DMA_TC_OFS = 1;
	localparam int DMA_COMB_OFS = 2;
	localparam int GPIO0_COMB_IDX = 69;
	localparam int GPIO1_COMB_IDX = 70;
	localparam int GPIO2_COMB_IDX = 71;
	localparam int GPIO3_COMB_BASE = 72;
	localparam int GPIO0_PIN_BASE = 88;
	localparam int GPIO1_PIN_BASE = 104;
	localparam int GPIO2_PIN_BASE = 120;
	localparam int GPIO3_PIN_BASE = 124;
	localparam int SERIAL5_RX_IDX = 125;
	localparam int SERIAL5_TX_IDX = 126;
	localparam int SERIAL5_COMB_IDX = 127;
	localparam int SERIAL5_PORT = 5;

	localparam logic [IRQ_COUNT-1:0] IRQ_RESET_VALUE = '0;
endpackage

// *** core/irq_source_or.sv ***
// Reduction OR that merges a group of interrupt sources into one line.
`timescale 1ns/1ps
module irq_source_or #(
	parameter int WIDTH = 12
) (
	input wire logic [WIDTH-1:0] srcIrq, // Sources to merge, active high.
	output logic mergedIrq // High while any source is high.
);
	always_comb begin
		mergedIrq = |srcIrq;
	end
endmodule

// *** core/expansion_irq_map.sv ***
// Expansion interrupt map: gathers peripheral interrupts onto the processor input vector.
// Contract
// R1: Watchdog reset request drives input 0, watchdog interrupt drives input 1.
// R2: Secure memory, peripheral, master and bridge interrupts drive inputs 9 to 12.
// R3: System timestamp counter interrupt drives input 32.
// R4: Serial ports 0-4: receive to 33+2n, transmit to 34+2n.
// R5: Serial ports 0-4 combined interrupts drive inputs 43 to 47 in order.
// R6: Serial port 5 receive, transmit, combined drive inputs 125, 126, 127.
// R7: Each serial transmit, receive, combined line has its own unmerged input.
// R8: All twelve serial overrun lines are ORed onto one overflow input.
// R9: DMA channels 1-3 give error, terminal count, combined from input 60 to 68.
// R10: GPIO 0-2 combined drive 69 to 71; GPIO 3 combined fills 72 to 87.
// R11: GPIO pins: port 0 to 88-103, 1 to 104-119, 2 to 120-123, 3 to 124.
// R12: Ethernet 49, audio 50, touch 51, USB 52, SPIs 53-55, accelerator 56.
// R13: Every reserved input, including 57-59 and 128-130, stays permanently inactive.
`timescale 1ns/1ps
module expansion_irq_map #(
	parameter int PORTS = irq_map_pkg::SERIAL_PORTS,
	parameter int DMAS = irq_map_pkg::DMA_CHANNELS
) (
	input wire logic clk, // System clock, 100 MHz.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic ce, // Clock enable; all state holds while low, except that a reset with nrst low still clears it.
	input wire logic wdogResetReq, // Non-secure watchdog reset request.
	input wire logic wdogIrq, // Non-secure watchdog interrupt.
	input wire logic secMemIrq, // Secure memory protection combined.
	input wire logic secPeriphIrq, // Secure peripheral protection combined.
	input wire logic secMasterIrq, // Secure master security combined.
	input wire logic secBridgeIrq, // Secure bridge error combined.
	input wire logic timestampIrq, // System timestamp counter interrupt.
	input wire logic [PORTS-1:0] rx_irq, // Serial receive interrupts.
	input wire logic [PORTS-1:0] tx_irq, // Serial transmit interrupts.
	input wire logic [PORTS-1:0] serial_combined_irq, // Serial combined interrupts.
	input wire logic [PORTS-1:0] tx_overrun_irq, // Serial transmit overrun.
	input wire logic [PORTS-1:0] rx_overrun_irq, // Serial receive overrun.
	input wire logic ethIrq, // Ethernet.
	input wire logic audioIrq, // Audio serial.
	input wire logic touchIrq, // Touch screen.
	input wire logic usbIrq, // USB.
	input wire logic adcSpiIrq, // Converter SPI.
	input wire logic [1:0] shieldSpiIrq, // Shield SPI ports 0 and 1.
	input wire logic npuIrq, // Neural accelerator.
	input wire logic [DMAS-1:0] dmaErrIrq, // DMA channel error, bit 0 is channel 1.
	input wire logic [DMAS-1:0] dmaTcIrq, // DMA channel terminal count.
	input wire logic [DMAS-1:0] dmaCombIrq, // DMA channel combined.
	input wire logic [2:0] gpioCombIrq, // GPIO ports 0 to 2 combined.
	input wire logic [irq_map_pkg::GPIO3_COMB_WIDTH-1:0] gpio3CombIrq, // GPIO port 3 combined.
	input wire logic [irq_map_pkg::GPIO0_PIN_WIDTH-1:0] gpio0PinIrq, // GPIO port 0 pins.
	input wire logic [irq_map_pkg::GPIO1_PIN_WIDTH-1:0] gpio1PinIrq, // GPIO port 1 pins.
	input wire logic [irq_map_pkg::GPIO2_PIN_WIDTH-1:0] gpio2PinIrq, // GPIO port 2 pins.
	input wire logic [irq_map_pkg::GPIO3_PIN_WIDTH-1:0] gpio3PinIrq, // GPIO port 3 pins.
	output logic [irq_map_pkg::IRQ_COUNT-1:0] irqVec_reg // Processor interrupt inputs.
);
	logic [irq_map_pkg::IRQ_COUNT-1:0] irqVec_next;
	logic overflowAny;

	// All overrun sources share one line; software must poll the ports to find the culprit.
	irq_source_or #(
		.WIDTH(2*PORTS)
	) overflowMerge (
		.srcIrq({tx_overrun_irq, rx_overrun_irq}), // R8
		.mergedIrq(overflowAny)
	);

	// Inputs come from logic on this clock, so no synchroniser; one register stage
	// keeps the vector glitch free at the processor boundary at a cost of one cycle.
	always_comb begin
		irqVec_next = irq_map_pkg::IRQ_RESET_VALUE; // R13
		irqVec_next[irq_map_pkg::WDOG_RESET_IDX] = wdogResetReq; // R1
		irqVec_next[irq_map_pkg::WDOG_IRQ_IDX] = wdogIrq; // R1
		irqVec_next[irq_map_pkg::SEC_MEM_IDX] = secMemIrq; // R2
		irqVec_next[irq_map_pkg::SEC_PERIPH_IDX] = secPeriphIrq; // R2
		irqVec_next[irq_map_pkg::SEC_MASTER_IDX] = secMasterIrq; // R2
		irqVec_next[irq_map_pkg::SEC_BRIDGE_IDX] = secBridgeIrq; // R2
		irqVec_next[irq_map_pkg::TIMESTAMP_IDX] = timestampIrq; // R3
		for (int n = 0; n < irq_map_pkg::SERIAL_LOW_PORTS; n++) begin
			irqVec_next[irq_map_pkg::SERIAL_RX_BASE + irq_map_pkg::SERIAL_PAIR_STEP*n] =
				rx_irq[n]; // R4 R7
			irqVec_next[irq_map_pkg::SERIAL_TX_BASE + irq_map_pkg::SERIAL_PAIR_STEP*n] =
				tx_irq[n]; // R4 R7
			irqVec_next[irq_map_pkg::SERIAL_COMB_BASE + n] = serial_combined_irq[n]; // R5 R7
		end
		irqVec_next[irq_map_pkg::SERIAL5_RX_IDX] = rx_irq[irq_map_pkg::SERIAL5_PORT]; // R6
		irqVec_next[irq_map_pkg::SERIAL5_TX_IDX] = tx_irq[irq_map_pkg::SERIAL5_PORT]; // R6
		irqVec_next[irq_map_pkg::SERIAL5_COMB_IDX] =
			serial_combined_irq[irq_map_pkg::SERIAL5_PORT]; // R6
		irqVec_next[irq_map_pkg::OVERFLOW_IDX] = overflowAny; // R8
		irqVec_next[irq_map_pkg::ETH_IDX] = ethIrq; // R12
		irqVec_next[irq_map_pkg::AUDIO_IDX] = audioIrq; // R12
		irqVec_next[irq_map_pkg::TOUCH_IDX] = touchIrq; // R12
		irqVec_next[irq_map_pkg::USB_IDX] = usbIrq; // R12
		irqVec_next[irq_map_pkg::ADC_SPI_IDX] = adcSpiIrq; // R12
		irqVec_next[irq_map_pkg::SHIELD0_SPI_IDX] = shieldSpiIrq[0]; // R12
		irqVec_next[irq_map_pkg::SHIELD1_SPI_IDX] = shieldSpiIrq[1]; // R12
		irqVec_next[irq_map_pkg::NPU_IDX] = npuIrq; // R12
		for (int c = 0; c < DMAS; c++) begin
			irqVec_next[irq_map_pkg::DMA_BASE + irq_map_pkg::DMA_STEP*c +
				irq_map_pkg::DMA_ERR_OFS] = dmaErrIrq[c]; // R9
			irqVec_next[irq_map_pkg::DMA_BASE + irq_map_pkg::DMA_STEP*c +
				irq_map_pkg::DMA_TC_OFS] = dmaTcIrq[c]; // R9
			irqVec_next[irq_map_pkg::DMA_BASE + irq_map_pkg::DMA_STEP*c +
				irq_map_pkg::DMA_COMB_OFS] = dmaCombIrq[c]; // R9
		end
		irqVec_next[irq_map_pkg::GPIO0_COMB_IDX] = gpioCombIrq[0]; // R10
		irqVec_next[irq_map_pkg::GPIO1_COMB_IDX] = gpioCombIrq[1]; // R10
		irqVec_next[irq_map_pkg::GPIO2_COMB_IDX] = gpioCombIrq[2]; // R10
		irqVec_next[irq_map_pkg::GPIO3_COMB_BASE +: irq_map_pkg::GPIO3_COMB_WIDTH] =
			gpio3CombIrq; // R10
		irqVec_next[irq_map_pkg::GPIO0_PIN_BASE +: irq_map_pkg::GPIO0_PIN_WIDTH] =
			gpio0PinIrq; // R11
		irqVec_next[irq_map_pkg::GPIO1_PIN_BASE +: irq_map_pkg::GPIO1_PIN_WIDTH] =
			gpio1PinIrq; // R11
		irqVec_next[irq_map_pkg::GPIO2_PIN_BASE +: irq_map_pkg::GPIO2_PIN_WIDTH] =
			gpio2PinIrq; // R11
		irqVec_next[irq_map_pkg::GPIO3_PIN_BASE +: irq_map_pkg::GPIO3_PIN_WIDTH] =
			gpio3PinIrq; // R11
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irqVec_reg <= irq_map_pkg::IRQ_RESET_VALUE;
		end else if (ce) begin
			irqVec_reg <= irqVec_next;
		end
	end

	// Checks. Each, save reserved_low_a and freeze_hold_a, ties a registered input line to the source sampled one enabled edge before.
	// The reset level is part of each trigger, so an edge that clears the vector is never judged.
	sequence enabledEdge;
		nrst && ce;
	endsequence

	sequence overrunSeen;
		nrst && ce && (|tx_overrun_irq || |rx_overrun_irq);
	endsequence

	sequence overrunQuiet;
		nrst && ce && !(|tx_overrun_irq) && !(|rx_overrun_irq);
	endsequence

	watchdog_map_a: assert property ( // R1
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[irq_map_pkg::WDOG_RESET_IDX] == $past(wdogResetReq) &&
			irqVec_reg[irq_map_pkg::WDOG_IRQ_IDX] == $past(wdogIrq))
		else $error("Watchdog lines do not follow their sources.");

	secure_map_a: assert property ( // R2
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[irq_map_pkg::SEC_BRIDGE_IDX:irq_map_pkg::SEC_MEM_IDX] ==
			$past({secBridgeIrq, secMasterIrq, secPeriphIrq, secMemIrq}))
		else $error("Secure combined lines are misplaced.");

	timestamp_map_a: assert property ( // R3
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[irq_map_pkg::TIMESTAMP_IDX] == $past(timestampIrq))
		else $error("Timestamp line does not follow its source.");

	serial_pair_a: assert property ( // R4
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[42:33] == $past({tx_irq[4], rx_irq[4], tx_irq[3],
			rx_irq[3], tx_irq[2], rx_irq[2], tx_irq[1], rx_irq[1], tx_irq[0], rx_irq[0]}))
		else $error("Serial receive and transmit lines are misplaced.");

	serial_combined_a: assert property ( // R5
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[47:43] == $past(serial_combined_irq[4:0]))
		else $error("Serial combined lines are misplaced.");

	serial_five_a: assert property ( // R6
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[127:125] == $past({serial_combined_irq[5], tx_irq[5],
			rx_irq[5]}))
		else $error("Serial port five lines are misplaced.");

	serial_unmerged_a: assert property ( // R7
		@(posedge clk) disable iff (!nrst)
		nrst && ce && rx_irq[0] && !tx_irq[0] |=> irqVec_reg[33] && !irqVec_reg[34])
		else $error("Serial lines leak into a neighbouring input.");

	overflow_set_a: assert property ( // R8
		@(posedge clk) disable iff (!nrst)
		overrunSeen |=> irqVec_reg[irq_map_pkg::OVERFLOW_IDX])
		else $error("Overrun did not raise the overflow line.");

	overflow_clear_a: assert property ( // R8
		@(posedge clk) disable iff (!nrst)
		overrunQuiet |=> !irqVec_reg[irq_map_pkg::OVERFLOW_IDX])
		else $error("Overflow line high without an overrun.");

	dma_map_a: assert property ( // R9
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[68:60] == $past({dmaCombIrq[2], dmaTcIrq[2], dmaErrIrq[2],
			dmaCombIrq[1], dmaTcIrq[1], dmaErrIrq[1], dmaCombIrq[0], dmaTcIrq[0], dmaErrIrq[0]}))
		else $error("DMA lines are misplaced.");

	gpio_combined_a: assert property ( // R10
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[87:69] == $past({gpio3CombIrq, gpioCombIrq}))
		else $error("GPIO combined lines are misplaced.");

	gpio_pins_a: assert property ( // R11
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[124:88] == $past({gpio3PinIrq, gpio2PinIrq, gpio1PinIrq,
			gpio0PinIrq}))
		else $error("GPIO pin lines are misplaced.");

	misc_map_a: assert property ( // R12
		@(posedge clk) disable iff (!nrst)
		enabledEdge |=> irqVec_reg[56:49] == $past({npuIrq, shieldSpiIrq, adcSpiIrq, usbIrq,
			touchIrq, audioIrq, ethIrq}))
		else $error("Peripheral lines are misplaced.");

	reserved_low_a: assert property ( // R13
		@(posedge clk) disable iff (!nrst)
		irqVec_reg[59:57] == 3'h0 && irqVec_reg[130:128] == 3'h0 &&
			irqVec_reg[8:2] == 7'h00 && irqVec_reg[31:13] == 19'h00000)
		else $error("A reserved input is active.");

	freeze_hold_a: assert property (
		@(posedge clk) disable iff (!nrst)
		nrst && !ce |=> $stable(irqVec_reg))
		else $error("Vector changed while the clock enable was low.");
endmodule

// *** tb/irq_vector_sink.sv ***
// Processor-side model that samples the interrupt input vector on every clock.
`timescale 1ns/1ps
module irq_vector_sink (
	input wire logic clk, // System clock.
	input wire logic [130:0] irqIn, // Interrupt input levels from the map.
	output logic [130:0] seenVec // Levels as the core last sampled them.
);
	// The core takes plain levels, so it sees the map one cycle late and keeps no history.
	always_ff @(posedge clk) begin
		seenVec <= irqIn;
	end
endmodule

// *** tb/tb.sv ***
// Self-checking testbench for the expansion interrupt map.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ceR = 1'b1;
	logic [109:0] stimR = '0;
	logic [130:0] irqVec;
	logic [130:0] seenVec;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	expansion_irq_map i_dut (.clk(clk), .nrst(nrst), .ce(ceR),
		.wdogResetReq(stimR[0]), .wdogIrq(stimR[1]), .secMemIrq(stimR[2]),
		.secPeriphIrq(stimR[3]), .secMasterIrq(stimR[4]), .secBridgeIrq(stimR[5]),
		.timestampIrq(stimR[6]), .rx_irq(stimR[12:7]), .tx_irq(stimR[18:13]),
		.serial_combined_irq(stimR[24:19]), .tx_overrun_irq(stimR[30:25]),
		.rx_overrun_irq(stimR[36:31]), .ethIrq(stimR[37]), .audioIrq(stimR[38]),
		.touchIrq(stimR[39]), .usbIrq(stimR[40]), .adcSpiIrq(stimR[41]),
		.shieldSpiIrq(stimR[43:42]), .npuIrq(stimR[44]), .dmaErrIrq(stimR[47:45]),
		.dmaTcIrq(stimR[50:48]), .dmaCombIrq(stimR[53:51]), .gpioCombIrq(stimR[56:54]),
		.gpio3CombIrq(stimR[72:57]), .gpio0PinIrq(stimR[88:73]),
		.gpio1PinIrq(stimR[104:89]), .gpio2PinIrq(stimR[108:105]),
		.gpio3PinIrq(stimR[109:109]), .irqVec_reg(irqVec));

	irq_vector_sink i_sink (.clk(clk), .irqIn(irqVec), .seenVec(seenVec));

	// Expected vector from the source levels; every bit not named here stays low.
	function automatic logic [130:0] mapVec(input logic [109:0] s);
		logic [130:0] v;
		v = '0;
		v[1:0] = s[1:0];
		v[12:9] = s[5:2];
		v[32] = s[6];
		for (int n = 0; n < 5; n++) begin
			v[33 + 2 * n] = s[7 + n];
			v[34 + 2 * n] = s[13 + n];
			v[43 + n] = s[19 + n];
		end
		v[125] = s[12];
		v[126] = s[18];
		v[127] = s[24];
		v[48] = |s[36:25];
		v[56:49] = s[44:37];
		for (int k = 0; k < 3; k++) begin
			v[60 + 3 * k] = s[45 + k];
			v[61 + 3 * k] = s[48 + k];
			v[62 + 3 * k] = s[51 + k];
		end
		v[87:69] = s[72:54];
		v[124:88] = s[109:73];
		return v;
	endfunction

	task automatic checkVec(input logic [130:0] exp);
		check_count++;
		if (irqVec !== exp) begin
			fails++;
			$display("Error at %0t: vector %h expected %h", $time, irqVec, exp);
		end
	endtask

	// Inputs change after one edge, are sampled at the next, and judged just after it.
	task automatic applyCheck(input logic [109:0] s);
		@(posedge clk);
		stimR <= s;
		@(posedge clk);
		#1 checkVec(mapVec(s));
	endtask

	task automatic walkRange(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			applyCheck(110'h1 << i);
		end
	endtask

	task automatic test_walk();
		walkRange(0, 1);
		walkRange(2, 5);
		walkRange(6, 6);
		walkRange(7, 11);
		walkRange(13, 17);
		walkRange(19, 23);
		walkRange(12, 12);
		walkRange(18, 18);
		walkRange(24, 24);
		walkRange(25, 36);
		walkRange(45, 53);
		walkRange(54, 72);
		walkRange(73, 109);
		walkRange(37, 44);
	endtask

	task automatic test_unmerged_and_reserved();
		applyCheck({85'h0, 25'h1ffff80});
		applyCheck('1);
		// The core samples one cycle late, so it still holds the vector of the previous step.
		#1 if (seenVec !== mapVec({85'h0, 25'h1ffff80})) begin
			fails++;
			$display("Error at %0t: core did not see the previous vector", $time);
		end
		@(posedge clk);
		#1 checkVec(mapVec('1));
		if (seenVec !== mapVec('1)) begin
			fails++;
			$display("Error at %0t: core sampled a wrong vector", $time);
		end
	endtask

	// Single-cycle pulse on each of two overrun lines in turn, then hold with the clock enable low.
	task automatic test_overflow_pulse_hold();
		@(posedge clk);
		stimR <= 110'h1 << 34;
		@(posedge clk);
		stimR <= '0;
		#1 checkVec(131'h1 << 48);
		@(posedge clk);
		#1 checkVec('0);
		applyCheck(110'h1 << 25);
		ceR <= 1'b0;
		stimR <= '0;
		repeat (2) @(posedge clk);
		#1 checkVec(131'h1 << 48);
		ceR <= 1'b1;
		@(posedge clk);
		#1 checkVec('0);
	endtask

	task automatic test_mid_reset();
		applyCheck('1);
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		#1 checkVec('0);
		@(posedge clk);
		#1 checkVec(mapVec('1));
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// The whole sequence needs a few hundred cycles; the ceiling leaves ample slack.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			$display("Error at %0t: run did not finish", $time);
			give_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		#1 checkVec('0);
		nrst <= 1'b1;
		test_walk();
		test_unmerged_and_reserved();
		test_overflow_pulse_hold();
		test_mid_reset();
		give_verdict();
	end
endmodule
